/* core/pci_dataflow_pkg.sv */
// shared constants and carrier types for the pci target backend data path
package pci_dataflow_pkg;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int ADDR_W = 16;
  localparam int WIN_W = 3;
  localparam int CNT_W = 4;
  localparam int PTR_W = 3;
  // word step on the backend address, in bytes
  localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0004;
  // initial backend latency limits, counted in clocks from transfer_begin_pulse
  localparam logic [CNT_W-1:0] RD_LIMIT = 4'hb;
  localparam logic [CNT_W-1:0] RD_LIMIT_PIPE = 4'ha;
  localparam logic [CNT_W-1:0] WR_LIMIT = 4'hd;
  // longest gap between two backend words inside a burst
  localparam logic [CNT_W-1:0] WORD_LIMIT = 4'h8;
  // prefetch buffer depth in words
  localparam logic [PTR_W-1:0] BUF_DEPTH = 3'h5;
  // command bit 0 tells a pci memory write from a read
  localparam int CMD_WRITE_BIT = 0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_START,
    ST_READ,
    ST_WRITE,
    ST_TERM,
    ST_DONE
  } phase_type;

  // backend port as seen by user memory or fifo logic
  typedef struct packed {
    logic transfer_begin_pulse;
    logic transfer_end_pulse;
    logic [WIN_W-1:0] window_index;
    logic read_cycle_flag;
    logic write_cycle_flag;
    logic [ADDR_W-1:0] backend_addr;
    logic [DATA_W-1:0] backend_write_bus;
    logic [LANES-1:0] byte_write_strobes;
  } backend_out_type;

  // target-side answer toward the pci pin controller
  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic [DATA_W-1:0] ad_out;
  } pci_out_type;
endpackage

/* core/pci_target_backend_dataflow.sv */
// pci target backend data path: pci target cycles to strobe-handshaked backend transfers
//
// Operation
// - pulse transfer_begin_pulse at each access, flag read or write and window.
// - window and cycle flags valid with begin pulse, held until end pulse.
// - window and cycle flags drop the clock after the end pulse.
// - reads may prefetch several words even for a single pci word.
// - a read word moves only when core_read_ready and backend_read_valid are high.
// - non-pipelined reads capture data at the edge where both strobes are high.
// - pipelined reads capture data one edge after both strobes were high.
// - begin two clocks after frame, read ready one later, data two more.
// - a missed initial read limit ends the pci cycle with a retry.
// - a missed per-word rate ends the pci cycle with disconnect without data.
// - build option adds one clock, reducing read limits to 10 or 9.
// - on writes trdy is given only while backend_write_ready is high.
// - byte_write_strobes come in the clock where address and write data are valid.
// - four byte strobes, one per lane; a byte write raises one strobe.
// - wider buses follow the same handshake timing and protocol.
`timescale 1ns/1ps
module pci_target_backend_dataflow
  import pci_dataflow_pkg::*;
#(
  parameter bit EXTRA_LATENCY = 1'b0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [LANES-1:0] cbe_n,
  input wire logic [DATA_W-1:0] ad_in,
  input wire logic [WIN_W-1:0] window_sel,
  input wire logic pipelined_read_select,
  input wire logic backend_read_valid,
  input wire logic [DATA_W-1:0] backend_read_data,
  input wire logic backend_write_ready,
  output logic core_read_ready,
  output backend_out_type backend_out,
  output pci_out_type pci_out
);

  typedef struct packed {
    phase_type phase;
    backend_out_type be;
    logic is_write;
    logic pipe;
    logic got_word;
    logic pend;
    logic out_valid;
    logic term;
    logic [CNT_W-1:0] wait_cnt;
    logic [PTR_W-1:0] count;
    logic [BUF_DEPTH-1:0][DATA_W-1:0] buf_word;
    logic [DATA_W-1:0] ad_out;
  } state_type;

  state_type st_reg;
  state_type st_next;
  logic rd_hs;
  logic wr_hs;
  logic push;
  logic pop;
  logic trdy;
  logic [PTR_W-1:0] cnt_after_pop;

  // initial read limit for this transfer, trimmed by the build option
  function automatic logic [CNT_W-1:0] read_limit(input logic pipe);
    logic [CNT_W-1:0] lim;
    lim = pipe ? RD_LIMIT_PIPE : RD_LIMIT;
    read_limit = lim - CNT_W'(EXTRA_LATENCY);
  endfunction

  // handshakes seen this cycle
  always_comb begin
    core_read_ready = (st_reg.phase == ST_READ) && (st_reg.count < BUF_DEPTH) && !st_reg.pend;
    rd_hs = core_read_ready && backend_read_valid;
    // trdy on writes follows the backend ready flag directly, so no word can be taken blind
    trdy = (st_reg.phase == ST_WRITE) ? backend_write_ready : (st_reg.phase == ST_READ) && st_reg.out_valid;
    wr_hs = (st_reg.phase == ST_WRITE) && trdy && !irdy_n;
    push = st_reg.pipe ? st_reg.pend : rd_hs;
    pop = (st_reg.phase == ST_READ) && !st_reg.out_valid && (st_reg.count != '0);
    cnt_after_pop = st_reg.count - PTR_W'(pop);
  end

  // next-state logic for the whole data path
  always_comb begin
    st_next = st_reg;
    st_next.be.transfer_begin_pulse = 1'b0;
    st_next.be.transfer_end_pulse = 1'b0;
    st_next.be.byte_write_strobes = '0;
    if (st_reg.wait_cnt != '1) begin
      st_next.wait_cnt = st_reg.wait_cnt + CNT_W'(1);
    end
    // address steps after the strobe clock, so strobes see the word's own address
    if (st_reg.be.byte_write_strobes != '0) begin
      st_next.be.backend_addr = st_reg.be.backend_addr + WORD_STEP;
    end
    unique case (st_reg.phase)
      ST_IDLE: begin
        if (!frame_n) begin
          st_next.phase = ST_DECODE;
          st_next.be.backend_addr = ad_in[ADDR_W-1:0];
          st_next.is_write = cbe_n[CMD_WRITE_BIT];
        end
      end
      ST_DECODE: begin
        // begin pulse, window and direction all show in the same clock
        st_next.phase = ST_START;
        st_next.be.transfer_begin_pulse = 1'b1;
        st_next.be.window_index = window_sel;
        st_next.be.read_cycle_flag = !st_reg.is_write;
        st_next.be.write_cycle_flag = st_reg.is_write;
        st_next.pipe = pipelined_read_select;
        st_next.got_word = 1'b0;
        st_next.wait_cnt = '0;
      end
      ST_START: begin
        st_next.phase = st_reg.is_write ? ST_WRITE : ST_READ;
      end
      ST_READ: begin
        // prefetch runs while there is room, the pci side may want fewer words
        if (rd_hs) begin
          st_next.be.backend_addr = st_reg.be.backend_addr + WORD_STEP;
          st_next.got_word = 1'b1;
          st_next.wait_cnt = '0;
          st_next.pend = st_reg.pipe;
        end else begin
          st_next.pend = 1'b0;
          if (!core_read_ready && st_reg.got_word) begin
            st_next.wait_cnt = '0;
          end
        end
        // buffer shift on pop, then append in the freed place
        if (pop) begin
          st_next.ad_out = st_reg.buf_word[0];
          st_next.out_valid = 1'b1;
          for (int i = 0; i < BUF_DEPTH - 1; i++) begin
            st_next.buf_word[i] = st_reg.buf_word[i+1];
          end
        end
        if (push) begin
          st_next.buf_word[cnt_after_pop] = backend_read_data;
        end
        st_next.count = cnt_after_pop + PTR_W'(push);
        if (st_reg.out_valid && !irdy_n) begin
          st_next.out_valid = 1'b0;
          if (frame_n) begin
            st_next.phase = ST_DONE;
            st_next.be.transfer_end_pulse = 1'b1;
          end
        end else if (!st_reg.got_word && st_reg.wait_cnt >= read_limit(st_reg.pipe) && !rd_hs) begin
          st_next.phase = ST_TERM;
          st_next.term = 1'b1;
        end else if (st_reg.got_word && st_reg.wait_cnt >= WORD_LIMIT && !rd_hs && !push
                     && st_reg.count == '0 && !st_reg.out_valid) begin
          st_next.phase = ST_TERM;
          st_next.term = 1'b1;
        end
      end
      ST_WRITE: begin
        if (wr_hs) begin
          st_next.be.backend_write_bus = ad_in;
          st_next.be.byte_write_strobes = ~cbe_n;
          st_next.got_word = 1'b1;
          st_next.wait_cnt = '0;
          if (frame_n) begin
            st_next.phase = ST_DONE;
            st_next.be.transfer_end_pulse = 1'b1;
          end
        end else if (!backend_write_ready) begin
          if ((!st_reg.got_word && st_reg.wait_cnt >= WR_LIMIT)
              || (st_reg.got_word && st_reg.wait_cnt >= WORD_LIMIT)) begin
            st_next.phase = ST_TERM;
            st_next.term = 1'b1;
          end
        end
      end
      ST_TERM: begin
        // stop holds until the initiator drops frame
        if (frame_n) begin
          st_next.phase = ST_DONE;
          st_next.term = 1'b0;
          st_next.be.transfer_end_pulse = 1'b1;
        end
      end
      ST_DONE: begin
        // prefetched words that pci never took are dropped here
        st_next.phase = ST_IDLE;
        st_next.be.window_index = '0;
        st_next.be.read_cycle_flag = 1'b0;
        st_next.be.write_cycle_flag = 1'b0;
        st_next.count = '0;
        st_next.pend = 1'b0;
        st_next.out_valid = 1'b0;
      end
      default: begin
        // the one unused phase code falls back to idle rather than locking up
        st_next.phase = ST_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; devsel, stop and ad_out come from registered state, trdy on writes follows backend_write_ready directly
  always_comb begin
    backend_out = st_reg.be;
    pci_out.devsel_n = (st_reg.phase == ST_IDLE) || (st_reg.phase == ST_DECODE) || (st_reg.phase == ST_DONE);
    pci_out.trdy_n = !trdy;
    pci_out.stop_n = !st_reg.term;
    pci_out.ad_out = st_reg.ad_out;
  end

endmodule // pci_target_backend_dataflow

/* verification/backend_mem_model.sv */
// behavioural backend memory: answers reads and writes after a set number of idle clocks
`timescale 1ns/1ps
module backend_mem_model
  import pci_dataflow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic pipe,
  input wire logic [7:0] wait_n,
  input wire logic core_read_ready,
  input wire backend_out_type bo,
  output logic backend_read_valid,
  output logic [DATA_W-1:0] backend_read_data,
  output logic backend_write_ready,
  output logic [DATA_W-1:0] wr_seen
);
  logic [7:0] cnt = 8'h00;
  logic [DATA_W-1:0] word = 32'h0000_0000;
  logic pend = 1'b0;
  wire take = backend_read_valid && core_read_ready;
  // gap counter restarts at each begin and each moved word, so one wait sets first and burst latency
  always @(posedge ref_clk) begin
    cnt <= (bo.transfer_begin_pulse || take || |bo.byte_write_strobes) ? 8'h00 : cnt + 8'h01;
    pend <= take && pipe;
    word <= bo.transfer_begin_pulse ? 32'h0000_0000 : word + 32'((take && !pipe) || pend);
    if (|bo.byte_write_strobes)
      wr_seen <= bo.backend_write_bus;
  end
  // data bus shows the inverse word when not driven, never a stale copy
  assign backend_read_valid = bo.read_cycle_flag && !pend && cnt >= wait_n;
  assign backend_read_data = (backend_read_valid || pend) ? word : ~word;
  assign backend_write_ready = bo.write_cycle_flag && cnt >= wait_n;
endmodule // backend_mem_model

/* verification/backend_dataflow_props.sv */
// concurrent checks on the backend data path ports
`timescale 1ns/1ps
module backend_dataflow_props
  import pci_dataflow_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [LANES-1:0] cbe_n,
  input wire logic [DATA_W-1:0] ad_in,
  input wire logic [WIN_W-1:0] window_sel,
  input wire logic pipelined_read_select,
  input wire logic backend_read_valid,
  input wire logic backend_write_ready,
  input wire logic core_read_ready,
  input wire backend_out_type backend_out,
  input wire pci_out_type pci_out
);
  // short aliases keep the properties on one line
  wire backend_out_type b = backend_out;
  wire pci_out_type p = pci_out;
  wire flags = b.read_cycle_flag || b.write_cycle_flag;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_BEGIN_DELAY: assert property ($fell(frame_n) |-> ##2 b.transfer_begin_pulse)
    else $error("begin pulse not two clocks after frame");
  AST_BEGIN_FLAGS: assert property (b.transfer_begin_pulse |-> b.window_index == $past(window_sel)
    && b.write_cycle_flag == $past(cbe_n[0], 2) && b.read_cycle_flag != b.write_cycle_flag)
    else $error("window or direction wrong at begin");
  AST_FLAGS_HOLD: assert property (flags && !b.transfer_end_pulse |=> flags && $stable(b.window_index))
    else $error("window or flags changed before end");
  AST_FLAGS_DROP: assert property (b.transfer_end_pulse |=> !flags && b.window_index == 3'h0)
    else $error("flags still up after end");
  AST_READ_READY: assert property (b.transfer_begin_pulse && b.read_cycle_flag |=> core_read_ready)
    else $error("read ready not one clock after begin");
  AST_READ_ADDR: assert property (core_read_ready && backend_read_valid && !pipelined_read_select
    |=> b.backend_addr == $past(b.backend_addr) + WORD_STEP)
    else $error("address not advanced after read word");
  AST_PIPE_GAP: assert property (core_read_ready && backend_read_valid && pipelined_read_select |=> !core_read_ready)
    else $error("read ready high during pipelined capture");
  AST_WRITE_STROBE: assert property (b.write_cycle_flag && !p.trdy_n && !irdy_n
    |=> b.byte_write_strobes == ~$past(cbe_n) && b.backend_write_bus == $past(ad_in)
    ##1 b.backend_addr == $past(b.backend_addr) + WORD_STEP)
    else $error("write strobes, data or address wrong");
  AST_STOP_NO_DATA: assert property (!p.stop_n |-> p.trdy_n)
    else $error("data phase during termination");
  AST_WRITE_TRDY: assert property (b.write_cycle_flag && !p.trdy_n |-> backend_write_ready)
    else $error("write trdy without backend ready");
  AST_DEVSEL_CLAIM: assert property (b.transfer_begin_pulse || core_read_ready || !p.trdy_n || !p.stop_n |-> !p.devsel_n)
    else $error("devsel not claimed while the target is active");
endmodule // backend_dataflow_props
bind pci_target_backend_dataflow backend_dataflow_props u_props (.ref_clk, .resetn, .frame_n, .irdy_n, .cbe_n,
  .ad_in, .window_sel, .pipelined_read_select, .backend_read_valid, .backend_write_ready, .core_read_ready,
  .backend_out, .pci_out);

/* verification/tb.sv */
// self-checking bench: pci initiator tasks against the data path and a backend model
`timescale 1ns/1ps
module tb;
  import pci_dataflow_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic frame_n = 1'b1;
  logic irdy_n = 1'b1;
  logic [LANES-1:0] cbe_n = 4'hf;
  logic [DATA_W-1:0] ad_in = 32'h0000_0000;
  logic [WIN_W-1:0] window_sel = 3'h0;
  logic pipe_sel = 1'b0;
  logic [7:0] wait_n = 8'h00;
  logic rd_valid, wr_ready, core_read_ready;
  logic [DATA_W-1:0] rd_data, wr_seen;
  backend_out_type backend_out;
  pci_out_type pci_out;
  int errors = 0;
  int checked = 0;
  always #5 ref_clk = ~ref_clk;
  pci_target_backend_dataflow u_dut (.ref_clk, .resetn, .frame_n, .irdy_n, .cbe_n, .ad_in, .window_sel,
    .pipelined_read_select(pipe_sel), .backend_read_valid(rd_valid), .backend_read_data(rd_data),
    .backend_write_ready(wr_ready), .core_read_ready, .backend_out, .pci_out);
  backend_mem_model u_mem (.ref_clk, .pipe(pipe_sel), .wait_n, .core_read_ready, .bo(backend_out),
    .backend_read_valid(rd_valid), .backend_read_data(rd_data), .backend_write_ready(wr_ready), .wr_seen);
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one pci transfer of n phases; backend turns slow after phase slow, expecting exp_n phases
  task automatic xfer(input bit wr, input bit pipe, input int n, input logic [7:0] w, input int slow, input int exp_n);
    int k;
    int done;
    done = 0;
    frame_n <= 1'b0;
    cbe_n <= {3'h3, wr};
    ad_in <= 32'h0000_0100;
    pipe_sel <= pipe;
    wait_n <= w;
    window_sel <= {wr, pipe, 1'b1};
    @(posedge ref_clk);
    irdy_n <= 1'b0;
    frame_n <= (n == 1);
    cbe_n <= 4'he;
    ad_in <= 32'h0000_0a00;
    for (k = 0; k < 60 && pci_out.stop_n !== 1'b0 && done < n; k++) begin
      @(posedge ref_clk);
      if (pci_out.trdy_n === 1'b0) begin
        if (!wr)
          cmp("ad_out", 32'(done), pci_out.ad_out);
        done++;
        if (done == slow)
          wait_n <= 8'd30;
        frame_n <= (done >= n - 1);
        cbe_n <= 4'h0;
        ad_in <= 32'h0000_0a00 + 32'(done);
      end
    end
    // irdy stays one more clock only to finish a stop handshake
    frame_n <= 1'b1;
    irdy_n <= pci_out.stop_n;
    @(posedge ref_clk);
    irdy_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmp("phases", 32'(exp_n), 32'(done));
    if (wr && exp_n > 0)
      cmp("wr_seen", 32'h0000_0a00 + 32'(exp_n - 1), wr_seen);
  endtask
  task automatic sc_read_single(); xfer(0, 0, 1, 8'd0, 0, 1); endtask
  task automatic sc_read_pipe_burst(); xfer(0, 1, 4, 8'd1, 0, 4); endtask
  task automatic sc_read_slow_backend(); xfer(0, 0, 3, 8'd3, 0, 3); endtask
  task automatic sc_read_retry(); xfer(0, 0, 2, 8'd30, 0, 0); endtask
  task automatic sc_read_pipe_retry(); xfer(0, 1, 1, 8'd30, 0, 0); endtask
  task automatic sc_write_burst(); xfer(1, 0, 4, 8'd0, 0, 4); endtask
  task automatic sc_write_slow(); xfer(1, 0, 3, 8'd2, 0, 3); endtask
  task automatic sc_write_retry(); xfer(1, 0, 1, 8'd30, 0, 0); endtask
  task automatic sc_write_disconnect(); xfer(1, 0, 3, 8'd0, 1, 1); endtask
  // main sequence after six reset clocks
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    sc_read_single();
    sc_read_pipe_burst();
    sc_read_slow_backend();
    sc_read_retry();
    sc_read_pipe_retry();
    sc_write_burst();
    sc_write_slow();
    sc_write_retry();
    sc_write_disconnect();
    tally_and_finish();
  end
  // watchdog at 5000 clocks, well beyond the at most 600 clocks the scenarios need
  initial begin
    #50000;
    errors++;
    tally_and_finish();
  end
endmodule // tb
